// file: logic/iodr_params.svh
/*
  Constants of the inertial output data registers: register indices,
  field positions, reset values and timing counts.
  Assumes a 125 MHz core clock and a word-wide Wishbone register bus.
*/
`ifndef IODR_PARAMS_SVH
`define IODR_PARAMS_SVH

`define IODR_CLK_HZ           125000000
`define IODR_INT_FS_HZ        2460
`define IODR_EXT_MIN_HZ       700
`define IODR_INT_PERIOD_CYC   (`IODR_CLK_HZ / `IODR_INT_FS_HZ)
`define IODR_EXT_MAX_PER_CYC  (`IODR_CLK_HZ / `IODR_EXT_MIN_HZ)
`define IODR_PER_W            18
`define IODR_PER_SAT          18'h3ffff
`define IODR_GAP_W            5
`define IODR_MIN_GAP          5'h10

// 0.02*2^15 / (1440 * 125e6) scaled by 2^48
`define IODR_ANG_SCALE        22'd1024819
`define IODR_ANG_LSB          48

`define IODR_IDX_Y_ACC_HI     8'h22
`define IODR_IDX_Z_ACC_LO     8'h24
`define IODR_IDX_Z_ACC_HI     8'h26
`define IODR_IDX_PRES_LO      8'h2e
`define IODR_IDX_PRES_HI      8'h30
`define IODR_IDX_XANG_LO      8'h40
`define IODR_IDX_XANG_HI      8'h42
`define IODR_IDX_DECIM        8'h60
`define IODR_IDX_CTRL         8'h61
`define IODR_IDX_STATUS       8'h62
`define IODR_IDX_PERIOD       8'h63

`define IODR_DEC_W            11
`define IODR_DEC_RST          11'h000
`define IODR_CTRL_EXT_BIT     0
`define IODR_STAT_SLOW_BIT    0
`define IODR_STAT_SRC_BIT     1

`endif

// file: logic/iodr_pkg.sv
/*
  Types of the inertial output data registers.
  Assumes the constants header is included where numbers are needed.
*/
package iodr_pkg;

  typedef enum logic [0:0]
  {
    IODR_SRC_INT = 1'b0,
    IODR_SRC_EXT = 1'b1
  } iodr_src_t;

endpackage

// file: logic/iodr_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
module iodr_sync
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;

endmodule

// file: logic/iodr_integrator.sv
/*
  Trapezoidal delta angle integrator for one axis.
  Assumes one-cycle sample strobes on core_clk and a sample period in
  core cycles supplied by the caller.
*/
`timescale 1ns/1ps
`include "iodr_params.svh"
module iodr_integrator
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    sampleEvt,
  input  wire logic [31:0]             rateIn,
  input  wire logic [`IODR_DEC_W-1:0]  decimation,
  input  wire logic [`IODR_PER_W-1:0]  periodCyc,
  output logic                         dumpPulse,
  output logic [31:0]                  angleOut
);

  logic signed [44:0]             acc_ff,   nxt_acc;
  logic signed [31:0]             prev_ff,  nxt_prev;
  logic [`IODR_DEC_W-1:0]         cnt_ff,   nxt_cnt;
  logic [31:0]                    angle_ff, nxt_angle;
  logic                           dump_ff,  nxt_dump;
  logic signed [44:0]             sum;
  logic signed [85:0]             prod;

  assign sum  = acc_ff + 45'($signed(rateIn)) + 45'(prev_ff);
  assign prod = sum * $signed({1'b0, periodCyc}) * $signed({1'b0, `IODR_ANG_SCALE});

  always_comb
  begin
    nxt_acc   = acc_ff;
    nxt_prev  = prev_ff;
    nxt_cnt   = cnt_ff;
    nxt_angle = angle_ff;
    nxt_dump  = 1'b0;
    if (sampleEvt)
    begin
      nxt_prev = $signed(rateIn);
      if (cnt_ff >= decimation)
      begin
        nxt_angle = prod[`IODR_ANG_LSB+31:`IODR_ANG_LSB];
        nxt_acc   = '0;
        nxt_cnt   = '0;
        nxt_dump  = 1'b1;
      end
      else
      begin
        nxt_acc = sum;
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_ff   <= '0;
      prev_ff  <= '0;
      cnt_ff   <= '0;
      angle_ff <= '0;
      dump_ff  <= 1'b0;
    end
    else
    begin
      acc_ff   <= nxt_acc;
      prev_ff  <= nxt_prev;
      cnt_ff   <= nxt_cnt;
      angle_ff <= nxt_angle;
      dump_ff  <= nxt_dump;
    end
  end

  assign angleOut  = angle_ff;
  assign dumpPulse = dump_ff;

endmodule

// file: logic/iodr_regs_top.sv
/*
  Output data registers: y/z acceleration, pressure and x delta angle,
  read over a classic Wishbone slave, with internal or external sample clock.
  Assumes sensor words come from logic on core_clk; the external sync pin
  is asynchronous.
*/
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "iodr_params.svh"
module iodr_regs_top
#(
  parameter int INT_PERIOD = `IODR_INT_PERIOD_CYC
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        extSyncPin,
  input  wire logic [31:0] yAccelIn,
  input  wire logic [31:0] zAccelIn,
  input  wire logic [31:0] pressureIn,
  input  wire logic [31:0] xRateIn,
  output logic             dataReady
);

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [`IODR_DEC_W-1:0] decim_ff, nxt_decim;
  iodr_pkg::iodr_src_t    src_ff,   nxt_src;
  logic                   ack_ff,   nxt_ack;
  logic [31:0]            rdat_ff,  nxt_rdat;
  logic [7:0]             regIdx;
  logic                   wrTake;

  assign regIdx = wb_adr_i[9:2];
  // Write lands on the edge the master sees ack
  assign wrTake = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

  always_comb
  begin
    nxt_decim = decim_ff;
    nxt_src   = src_ff;
    if (wrTake && regIdx == `IODR_IDX_DECIM)
    begin
      if (wb_sel_i[0])
      begin
        nxt_decim[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        nxt_decim[`IODR_DEC_W-1:8] = wb_dat_i[`IODR_DEC_W-1:8];
      end
    end
    if (wrTake && regIdx == `IODR_IDX_CTRL && wb_sel_i[0])
    begin
      nxt_src = iodr_pkg::iodr_src_t'(wb_dat_i[`IODR_CTRL_EXT_BIT]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      decim_ff <= `IODR_DEC_RST;
      src_ff   <= iodr_pkg::IODR_SRC_INT;
    end
    else
    begin
      decim_ff <= nxt_decim;
      src_ff   <= nxt_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample clocks

  logic                   extSync;
  logic                   extDly_ff,  nxt_extDly;
  logic [`IODR_PER_W-1:0] tmr_ff,     nxt_tmr;
  logic [`IODR_PER_W-1:0] extCnt_ff,  nxt_extCnt;
  logic [`IODR_PER_W-1:0] measPer_ff, nxt_measPer;
  logic                   slow_ff,    nxt_slow;
  logic                   intTick;
  logic                   extTick;
  logic                   sampleEvt;
  logic [`IODR_PER_W-1:0] periodCyc;

  iodr_sync u_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .asyncIn  (extSyncPin),
    .syncOut  (extSync)
  );

  assign intTick = (tmr_ff == `IODR_PER_W'(INT_PERIOD - 1));
  assign extTick = extSync & ~extDly_ff;

  always_comb
  begin
    nxt_extDly  = extSync;
    nxt_tmr     = intTick ? '0 : tmr_ff + 1'b1;
    nxt_measPer = measPer_ff;
    nxt_slow    = slow_ff;
    nxt_extCnt  = (extCnt_ff == `IODR_PER_SAT) ? extCnt_ff : extCnt_ff + 1'b1;
    if (extTick)
    begin
      nxt_extCnt  = `IODR_PER_W'(1);
      nxt_measPer = extCnt_ff;
      // flag an external clock slower than allowed
      nxt_slow    = (extCnt_ff > `IODR_PER_W'(`IODR_EXT_MAX_PER_CYC));
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      extDly_ff  <= 1'b0;
      tmr_ff     <= '0;
      extCnt_ff  <= '0;
      measPer_ff <= '0;
      slow_ff    <= 1'b0;
    end
    else
    begin
      extDly_ff  <= nxt_extDly;
      tmr_ff     <= nxt_tmr;
      extCnt_ff  <= nxt_extCnt;
      measPer_ff <= nxt_measPer;
      slow_ff    <= nxt_slow;
    end
  end

  assign periodCyc = (src_ff == iodr_pkg::IODR_SRC_EXT) ? measPer_ff : `IODR_PER_W'(INT_PERIOD);

  ////////////////////////////////////////////////////////////////////////
  // Sample spacing guard

  logic                   rawEvt;
  logic                   gapOk;
  logic                   pend_ff,    nxt_pend;
  logic [`IODR_GAP_W-1:0] gap_ff,     nxt_gap;

  assign rawEvt = (src_ff == iodr_pkg::IODR_SRC_EXT) ? extTick : intTick;
  assign gapOk  = (gap_ff == `IODR_MIN_GAP);

  always_comb
  begin
    nxt_pend  = pend_ff;
    nxt_gap   = gapOk ? gap_ff : gap_ff + 1'b1;
    sampleEvt = 1'b0;
    if ((rawEvt || pend_ff) && gapOk)
    begin
      sampleEvt = 1'b1;
      nxt_pend  = 1'b0;
      nxt_gap   = '0;
    end
    else if (rawEvt)
    begin
      nxt_pend = 1'b1;
    end
  end

  // Source switch cannot squeeze two samples together
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_ff <= 1'b0;
      gap_ff  <= `IODR_MIN_GAP;
    end
    else
    begin
      pend_ff <= nxt_pend;
      gap_ff  <= nxt_gap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delta angle and output words

  logic        dump;
  logic [31:0] xAngle;
  logic [31:0] yAcc_ff,  nxt_yAcc;
  logic [31:0] zAcc_ff,  nxt_zAcc;
  logic [31:0] pres_ff,  nxt_pres;
  logic        rdy_ff,   nxt_rdy;

  iodr_integrator u_xang
  (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .sampleEvt  (sampleEvt),
    .rateIn     (xRateIn),
    .decimation (decim_ff),
    .periodCyc  (periodCyc),
    .dumpPulse  (dump),
    .angleOut   (xAngle)
  );

  always_comb
  begin
    nxt_yAcc = yAcc_ff;
    nxt_zAcc = zAcc_ff;
    nxt_pres = pres_ff;
    nxt_rdy  = dump;
    if (dump)
    begin
      // pressure kept as one 32-bit word
      nxt_yAcc = yAccelIn;
      nxt_zAcc = zAccelIn;
      nxt_pres = pressureIn;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      yAcc_ff <= '0;
      zAcc_ff <= '0;
      pres_ff <= '0;
      rdy_ff  <= 1'b0;
    end
    else
    begin
      yAcc_ff <= nxt_yAcc;
      zAcc_ff <= nxt_zAcc;
      pres_ff <= nxt_pres;
      rdy_ff  <= nxt_rdy;
    end
  end

  assign dataReady = rdy_ff;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone read path

  always_comb
  begin
    nxt_ack  = wb_cyc_i & wb_stb_i & ~ack_ff;
    nxt_rdat = rdat_ff;
    if (nxt_ack)
    begin
      nxt_rdat = 32'h0000_0000;
      // high word bits 31..16, low word bits 15..0
      case (regIdx)
        // y high word, 0.8 mg counts
        `IODR_IDX_Y_ACC_HI: nxt_rdat[15:0] = yAcc_ff[31:16];
        `IODR_IDX_Z_ACC_LO: nxt_rdat[15:0] = zAcc_ff[15:0];
        `IODR_IDX_Z_ACC_HI: nxt_rdat[15:0] = zAcc_ff[31:16];
        `IODR_IDX_PRES_LO:  nxt_rdat[15:0] = pres_ff[15:0];
        `IODR_IDX_PRES_HI:  nxt_rdat[15:0] = pres_ff[31:16];
        `IODR_IDX_XANG_LO:  nxt_rdat[15:0] = xAngle[15:0];
        `IODR_IDX_XANG_HI:  nxt_rdat[15:0] = xAngle[31:16];
        `IODR_IDX_DECIM:    nxt_rdat[`IODR_DEC_W-1:0] = decim_ff;
        `IODR_IDX_CTRL:     nxt_rdat[`IODR_CTRL_EXT_BIT] = src_ff;
        `IODR_IDX_STATUS:
        begin
          nxt_rdat[`IODR_STAT_SLOW_BIT] = slow_ff;
          nxt_rdat[`IODR_STAT_SRC_BIT]  = src_ff;
        end
        `IODR_IDX_PERIOD:   nxt_rdat[`IODR_PER_W-1:0] = periodCyc;
        default:            nxt_rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule

// file: bench/iodr_host.sv
/*
  Host model: classic Wishbone master with a settable idle gap.
  Assumes the caller waits for reset release first.
*/
`timescale 1ns/1ps
module iodr_host
(
  input  wire logic        core_clk,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic [9:0]       wb_adr_i,
  output logic [3:0]       wb_sel_i,
  output logic [31:0]      wb_dat_i
);
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
  end

  // Hold request until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd,
                      input int gap, output logic [31:0] rdat);
    repeat (gap + 1) @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do
    begin
      @(posedge core_clk);
    end
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
endmodule

// file: bench/iodr_regs_assertions.sv
/*
  Port checker of the output data registers.
  Assumes one clock domain and the bind below.
*/
`timescale 1ns/1ps
module iodr_regs_assertions
#(
  parameter int INT_PERIOD = 20
)
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        dataReady
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] idxW;
  assign idxW = wb_adr_i[9:2];

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && !($past(idxW) inside
    {8'h22, 8'h24, 8'h26, 8'h2e, 8'h30, 8'h40, 8'h42, 8'h60, 8'h61, 8'h62, 8'h63}) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_word_upper: assert property (wb_ack_o && !$past(wb_we_i) && ($past(idxW) inside
    {8'h22, 8'h24, 8'h26, 8'h2e, 8'h30, 8'h40, 8'h42}) |-> wb_dat_o[31:16] == 16'h0)
    else $error("word upper bits set");
  a_decim_width: assert property (wb_ack_o && !$past(wb_we_i) && $past(idxW) == 8'h60
    |-> wb_dat_o[31:11] == 21'h0)
    else $error("decimation too wide");
  a_ready_gap: assert property (dataReady |=> !dataReady [*8])
    else $error("ready pulses too close");
  a_reset_quiet: assert property ($rose(rst_b) |-> !dataReady [*8])
    else $error("ready right after reset");
endmodule

bind iodr_regs_top iodr_regs_assertions #(.INT_PERIOD(INT_PERIOD)) chk_u
(
  .core_clk  (core_clk),
  .rst_b     (rst_b),
  .wb_cyc_i  (wb_cyc_i),
  .wb_stb_i  (wb_stb_i),
  .wb_we_i   (wb_we_i),
  .wb_adr_i  (wb_adr_i),
  .wb_dat_o  (wb_dat_o),
  .wb_ack_o  (wb_ack_o),
  .dataReady (dataReady)
);

// file: bench/testbench.sv
/*
  Self-checking bench of the output data registers.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`include "iodr_params.svh"
module testbench;
  localparam int PER  = 20;
  localparam int EXTP = 40;
  localparam logic [7:0] IDXT [8] = '{8'h22, 8'h24, 8'h26, 8'h2e, 8'h30, 8'h40, 8'h42, 8'h60};
  logic        core_clk, rst_b, extSyncPin, wbCyc, wbStb, wbWe, wbAck, dataReady;
  logic [31:0] yAccel, zAccel, pressure, xRate, wbDatW, wbDatR, ang;
  logic [9:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [5:0]  extCnt;
  integer      seed;
  int          err_count, checks_done, d, per;

  iodr_regs_top #(.INT_PERIOD(PER)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .extSyncPin(extSyncPin), .yAccelIn(yAccel),
    .zAccelIn(zAccel), .pressureIn(pressure), .xRateIn(xRate), .dataReady(dataReady));
  iodr_host host_u (.core_clk(core_clk), .wb_ack_o(wbAck), .wb_dat_o(wbDatR), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      extCnt     <= 6'h00;
      extSyncPin <= 1'b0;
    end
    else
    begin
      extCnt     <= (extCnt == EXTP - 1) ? 6'h00 : extCnt + 6'h01;
      extSyncPin <= (extCnt < EXTP / 2);
    end
  end
  //////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    host_u.xfer(1'b0, idx, 32'h0, $random(seed) & 3, v);
    checks_done++;
    if (v !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, v);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] dummy;
    host_u.xfer(1'b1, idx, v, $random(seed) & 3, dummy);
  endtask
  task automatic wait_ready(input int k);
    repeat (k)
    begin
      do
      begin
        @(posedge core_clk);
      end
      while (dataReady !== 1'b1);
    end
  endtask
  function automatic logic [31:0] angle(input logic [31:0] w, input int dd, input int p);
    logic signed [79:0] s;
    s = signed'(w);
    s = s * (2 * (dd + 1) * p) * int'(`IODR_ANG_SCALE);
    return s[79:48];
  endfunction

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
  initial
  begin
    seed = 32'hada0;
    rst_b = 1'b0;
    {yAccel, zAccel, pressure, xRate} = 128'h0;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (IDXT[i]) rdchk("reset", IDXT[i], 32'h0);
    rdchk("unmapped", 8'h10, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      d = (r == 3) ? 3 : ($random(seed) & 3);
      per = (r >= 2) ? EXTP : PER;
      yAccel <= $random(seed);
      zAccel <= $random(seed);
      pressure <= $random(seed);
      xRate <= (r == 3) ? 32'h7fffffff : $random(seed);
      wr(8'h60, d);
      wr(8'h61, r >= 2);
      wait_ready(4);
      ang = angle(xRate, d, per);
      rdchk("period", 8'h63, per);
      rdchk("source", 8'h62, {30'h0, r >= 2, 1'b0});
      rdchk("decim", 8'h60, d);
      wr(8'h24, 32'hffff);
      rdchk("z lo", 8'h24, zAccel[15:0]);
      wr(8'h26, 32'h1234);
      rdchk("z hi", 8'h26, zAccel[31:16]);
      rdchk("y hi", 8'h22, yAccel[31:16]);
      rdchk("p lo", 8'h2e, pressure[15:0]);
      rdchk("p hi", 8'h30, pressure[31:16]);
      rdchk("x lo", 8'h40, ang[15:0]);
      rdchk("x hi", 8'h42, ang[31:16]);
    end
    end_sim();
  end
endmodule
